//--- xss_pkg.sv
/*
  Package for the xor/swap/sign-extend execution unit: encodings,
  field positions, status word layout, bus offsets and reset values.
  Assumes one core clock and an Avalon-MM register slave.
*/
package xss_pkg;
  // ****************************************************************
  // Instruction field encodings
  // ****************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [4:0] SWAP_DD = 5'h08;
  localparam logic [4:0] SWAP_AA = 5'h09;
  localparam logic [4:0] SWAP_DA = 5'h11;
  localparam logic [2:0] SX_BW = 3'h2;
  localparam logic [2:0] SX_WL = 3'h3;
  localparam logic [2:0] SX_BL = 3'h7;
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_AREG = 3'h1;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] EXTREG_ABSW = 3'h0;
  localparam logic [2:0] EXTREG_ABSL = 3'h1;
  // ****************************************************************
  // Status word layout
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_X = 4;
  localparam int SUPER_BIT = 13;
  localparam logic [15:0] STATUS_IMPL_MASK = 16'hF71F;
  localparam logic [15:0] STATUS_RESET = 16'h2700;
  // ****************************************************************
  // Register map (word addresses, byte address = 4 * index)
  // ****************************************************************
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_EXT = 4'h1;
  localparam logic [3:0] REG_SWORD = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_FILE0 = 4'h8;
  // Status bits: done, illegal, privilege trap
  localparam int EV_DONE = 0;
  localparam int EV_ILL = 1;
  localparam int EV_PRIV = 2;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // Operation classes written in command bits [17:16]
  localparam logic [1:0] CLS_XOR = 2'h0;
  localparam logic [1:0] CLS_SWAP = 2'h1;
  localparam logic [1:0] CLS_EXT = 2'h2;
  localparam logic [1:0] CLS_XSR = 2'h3;
endpackage : xss_pkg

//--- xss_alu_if.sv
/*
  Interface between the sequencer and the combinational datapath.
  Assumes both ends run in one clock domain.
*/
`timescale 1ns/100ps
interface xss_alu_if;
  logic [1:0] size;
  logic [31:0] imm;
  logic [31:0] dst;
  logic [31:0] res;
  logic [3:0] nzvc;
  modport ctl (output size, output imm, output dst, input res, input nzvc);
  modport alu (input size, input imm, input dst, output res, output nzvc);
endinterface : xss_alu_if

//--- xss_xor_alu.sv
/*
  Sized exclusive-OR datapath with flag generation.
  Assumes operands held stable by the sequencer.
*/
`timescale 1ns/100ps
module xss_xor_alu (
  xss_alu_if.alu a
);
  logic [31:0] r;
  logic neg;
  logic zero;
  always_comb begin
    r = a.dst ^ a.imm; // [RULE_01]
    case (a.size) // [RULE_02]
      xss_pkg::SIZE_BYTE: begin
        r = {a.dst[31:8], r[7:0]};
        neg = r[7];
        zero = (r[7:0] == 8'h00);
      end
      xss_pkg::SIZE_WORD: begin
        r = {a.dst[31:16], r[15:0]};
        neg = r[15];
        zero = (r[15:0] == 16'h0000);
      end
      default: begin
        neg = r[31];
        zero = (r == 32'h0000_0000);
      end
    endcase
  end
  assign a.res = r;
  assign a.nzvc = {neg, zero, 2'b00}; // [RULE_04]
endmodule : xss_xor_alu

//--- xss_unit.sv
/*
  Execution unit for xor-immediate (data register, condition code byte,
  status word), register swap and sign extension, with a 16-entry
  register file (8 data, 8 address) and an Avalon-MM control slave.
  Assumes memory destinations are handled by the effective-address
  stage; this unit only checks them for legality.
*/
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps

// Overview of operation
// RULE_01: xor-immediate combines immediate with destination and writes back.
// RULE_02: Size field 00/01/10 picks byte, word or long.
// RULE_03: Immediate is low byte, whole word, or two extension words.
// RULE_04: Data xor sets N and Z, clears V and C, keeps X.
// RULE_05: Destination must be data-alterable; address, immediate, PC barred.
// RULE_06: Condition code xor is byte-sized on the status low byte.
// RULE_07: Immediate bits 4..0 toggle X, N, Z, V, C.
// RULE_08: Status word xor only in supervisor state, else trap.
// RULE_09: Status word xor affects every implemented status bit.
// RULE_10: Swap exchanges two full 32-bit registers, flags untouched.
// RULE_11: Swap opmode 01000, 01001, 10001 select DD, AA, DA.
// RULE_12: Mixed swap: first field data, second field address.
// RULE_13: Byte-to-word copies bit 7 into bits 15:8.
// RULE_14: Word-to-long copies bit 15 into all upper bits.
// RULE_15: Byte-to-long copies bit 7 into bits 31:8.
// RULE_16: Extend opmode 010, 011, 111 select the three forms.
// RULE_17: Extend sets N and Z, clears V and C, keeps X.
// RULE_18: Illegal destination mode raises illegal, nothing executes.
module xss_unit (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq_q
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum {ST_IDLE, ST_EXEC, ST_ACK} state_e;
  state_e state_q;
  logic [31:0] regs_q [16];
  logic [15:0] status_word_q;
  logic [31:0] cmd_q;
  logic [31:0] ext_q;
  logic [2:0] stat_q;
  logic [2:0] mask_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic go_q;
  logic [2:0] ev_set;
  logic [31:0] lane_mask;

  xss_alu_if alu_bus ();
  xss_xor_alu u_alu (.a(alu_bus));

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [1:0] cls;
  logic [1:0] size;
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic [2:0] first_reg;
  logic [4:0] swap_op;
  logic [2:0] ext_op;
  logic [15:0] opw;
  logic ea_legal;
  logic [31:0] imm;
  logic [31:0] dreg;
  logic [31:0] sx;
  logic sx_ok;
  logic [3:0] sx_idx_a;
  logic [3:0] sx_idx_b;
  logic swap_ok;
  logic is_ccb;

  assign cls = cmd_q[17:16];
  assign opw = cmd_q[15:0];
  assign size = opw[7:6];
  assign ea_mode = opw[5:3];
  assign ea_reg = opw[2:0];
  assign first_reg = opw[11:9];
  assign swap_op = opw[7:3];
  assign ext_op = opw[8:6];
  // Bit 18 selects condition code byte form of the status xor
  assign is_ccb = cmd_q[18];

  always_comb begin
    // Data-alterable check [RULE_05]
    ea_legal = 1'b0;
    if (ea_mode == xss_pkg::MODE_EXT) begin
      ea_legal = (ea_reg == xss_pkg::EXTREG_ABSW) ||
                 (ea_reg == xss_pkg::EXTREG_ABSL);
    end else begin
      ea_legal = (ea_mode != xss_pkg::MODE_AREG);
    end
    if (size == 2'h3) begin
      ea_legal = 1'b0;
    end
  end

  always_comb begin
    case (size) // [RULE_03]
      xss_pkg::SIZE_BYTE: imm = {24'h000000, ext_q[7:0]};
      xss_pkg::SIZE_WORD: imm = {16'h0000, ext_q[15:0]};
      default: imm = ext_q;
    endcase
  end

  assign dreg = regs_q[{1'b0, ea_reg}];
  assign alu_bus.size = size;
  assign alu_bus.imm = imm;
  assign alu_bus.dst = dreg;

  always_comb begin
    sx_ok = 1'b1;
    case (ext_op) // [RULE_16]
      xss_pkg::SX_BW: sx = {dreg[31:16], {8{dreg[7]}}, dreg[7:0]}; // [RULE_13]
      xss_pkg::SX_WL: sx = {{16{dreg[15]}}, dreg[15:0]}; // [RULE_14]
      xss_pkg::SX_BL: sx = {{24{dreg[7]}}, dreg[7:0]}; // [RULE_15]
      default: begin
        sx = dreg;
        sx_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    swap_ok = 1'b1;
    sx_idx_a = {1'b0, first_reg};
    sx_idx_b = {1'b0, ea_reg};
    case (swap_op) // [RULE_11]
      xss_pkg::SWAP_DD: begin
        sx_idx_a = {1'b0, first_reg};
        sx_idx_b = {1'b0, ea_reg};
      end
      xss_pkg::SWAP_AA: begin
        sx_idx_a = {1'b1, first_reg};
        sx_idx_b = {1'b1, ea_reg};
      end
      xss_pkg::SWAP_DA: begin
        sx_idx_a = {1'b0, first_reg}; // [RULE_12]
        sx_idx_b = {1'b1, ea_reg}; // [RULE_12]
      end
      default: swap_ok = 1'b0;
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (go_q) state_q <= ST_EXEC;
        ST_EXEC: state_q <= ST_ACK;
        ST_ACK: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Execution results; the bus may also write the register file, but only
  // while the sequencer is idle; a bus status word write yields to execution.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= 32'h0000_0000;
      end
      status_word_q <= xss_pkg::STATUS_RESET;
      ev_set <= 3'h0;
    end else begin
      ev_set <= 3'h0;
      if (state_q == ST_EXEC) begin
        ev_set[xss_pkg::EV_DONE] <= 1'b1;
        case (cls)
          xss_pkg::CLS_XOR: begin
            if (!ea_legal) begin
              ev_set[xss_pkg::EV_ILL] <= 1'b1; // [RULE_18]
            end else if (ea_mode == xss_pkg::MODE_DREG) begin
              regs_q[{1'b0, ea_reg}] <= alu_bus.res; // [RULE_01]
              status_word_q[3:0] <= alu_bus.nzvc; // [RULE_04]
            end
          end
          xss_pkg::CLS_SWAP: begin
            if (swap_ok) begin
              regs_q[sx_idx_a] <= regs_q[sx_idx_b]; // [RULE_10]
              regs_q[sx_idx_b] <= regs_q[sx_idx_a]; // [RULE_10]
            end else begin
              ev_set[xss_pkg::EV_ILL] <= 1'b1;
            end
          end
          xss_pkg::CLS_EXT: begin
            if (sx_ok) begin
              regs_q[{1'b0, ea_reg}] <= sx;
              status_word_q[xss_pkg::FLAG_N] <= sx_neg(ext_op, sx); // [RULE_17]
              status_word_q[xss_pkg::FLAG_Z] <= sx_zero(ext_op, sx); // [RULE_17]
              status_word_q[xss_pkg::FLAG_V] <= 1'b0; // [RULE_17]
              status_word_q[xss_pkg::FLAG_C] <= 1'b0; // [RULE_17]
            end else begin
              ev_set[xss_pkg::EV_ILL] <= 1'b1;
            end
          end
          default: begin
            if (is_ccb) begin
              // Only the five flags exist in the low byte [RULE_06] [RULE_07]
              status_word_q[4:0] <= status_word_q[4:0] ^ ext_q[4:0];
            end else if (status_word_q[xss_pkg::SUPER_BIT]) begin
              status_word_q <= (status_word_q ^ ext_q[15:0]) &
                               xss_pkg::STATUS_IMPL_MASK; // [RULE_08] [RULE_09]
            end else begin
              ev_set[xss_pkg::EV_PRIV] <= 1'b1; // [RULE_08]
            end
          end
        endcase
      end else if (avs_write && wait_q && state_q == ST_IDLE &&
                   avs_address[5:4] != 2'h0) begin
        regs_q[avs_address[3:0]] <= (regs_q[avs_address[3:0]] & ~lane_mask) |
                                    (avs_writedata & lane_mask);
      end else if (avs_write && wait_q &&
                   avs_address == 6'(xss_pkg::REG_SWORD)) begin
        status_word_q <= avs_writedata[15:0] & xss_pkg::STATUS_IMPL_MASK;
      end
    end
  end

  function automatic logic sx_neg(input logic [2:0] op,
                                  input logic [31:0] v);
    sx_neg = (op == xss_pkg::SX_BW) ? v[15] : v[31];
  endfunction : sx_neg

  function automatic logic sx_zero(input logic [2:0] op,
                                   input logic [31:0] v);
    sx_zero = (op == xss_pkg::SX_BW) ? (v[15:0] == 16'h0000) :
              (v == 32'h0000_0000);
  endfunction : sx_zero

  // ****************************************************************
  // Bus slave: one wait cycle for every access
  // ****************************************************************
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      lane_mask[8*b +: 8] = {8{avs_byteenable[b]}};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end
  assign avs_waitrequest = wait_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= 32'h0000_0000;
      ext_q <= 32'h0000_0000;
      mask_q <= 3'h0;
      go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (avs_write && wait_q && state_q == ST_IDLE) begin
        case (avs_address)
          6'(xss_pkg::REG_CMD): begin
            cmd_q <= avs_writedata;
            go_q <= 1'b1;
          end
          6'(xss_pkg::REG_EXT): ext_q <= avs_writedata;
          6'(xss_pkg::REG_MASK): mask_q <= avs_writedata[2:0];
          default: ;
        endcase
      end
    end
  end

  // Sticky events: a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= 3'h0;
    end else if (avs_write && wait_q &&
                 avs_address == 6'(xss_pkg::REG_STAT)) begin
      stat_q <= (stat_q & ~avs_writedata[2:0]) | ev_set;
    end else begin
      stat_q <= stat_q | ev_set;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= xss_pkg::UNMAPPED_READ;
    end else if (avs_read && wait_q) begin
      if (avs_address[5:4] != 2'h0) begin
        rdata_q <= regs_q[avs_address[3:0]];
      end else begin
        case (avs_address)
          6'(xss_pkg::REG_CMD): rdata_q <= {31'h0, state_q != ST_IDLE};
          6'(xss_pkg::REG_EXT): rdata_q <= ext_q;
          6'(xss_pkg::REG_SWORD): rdata_q <= {16'h0000, status_word_q};
          6'(xss_pkg::REG_STAT): rdata_q <= {29'h0, stat_q};
          6'(xss_pkg::REG_MASK): rdata_q <= {29'h0, mask_q};
          default: rdata_q <= xss_pkg::UNMAPPED_READ;
        endcase
      end
    end
  end
  assign avs_readdata = rdata_q;
endmodule : xss_unit

//--- xss_unit_chk.sv
/* Checker for the unit's bus slave and interrupt pin.
   Assumes it is bound to the unit's top module. */
`timescale 1ns/100ps
module xss_unit_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Bus slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Interrupt
  input wire logic irq_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic req;
  assign req = avs_read | avs_write;
  answer_next_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  wait_cause_a: assert property (!avs_waitrequest |-> req && $past(req))
    else $error("answer without request");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == 6'h05 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  status_unimpl_a: assert property (
    avs_read && !avs_waitrequest && avs_address == 6'h02 |->
    (avs_readdata & ~{16'h0, xss_pkg::STATUS_IMPL_MASK}) == 32'h0)
    else $error("unimplemented status bits set");
  // Two edges: the interrupt flop lags the mask by one cycle
  mask_off_a: assert property (avs_write && !avs_waitrequest &&
    avs_address == 6'h04 && avs_writedata[2:0] == 3'h0 |=> ##1 !irq_q)
    else $error("interrupt stays up when masked");
  reset_quiet_a: assert property ($rose(nrst) |->
    avs_waitrequest && !irq_q && avs_readdata == 32'h0)
    else $error("outputs not quiet after reset");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data changed without read");
endmodule : xss_unit_chk
bind xss_unit xss_unit_chk chk_i (.mclk(mclk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_q(irq_q));

//--- xss_unit_tb.sv
/* Self-checking bench for the xor/swap/sign-extend unit.
   Assumes the unit's register map and command format. */
`timescale 1ns/100ps
module xss_unit_tb;
  // **********
  // Signals
  // **********
  logic mclk;
  logic nrst;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq_q;
  int fail_count;
  int tests_run;
  logic [31:0] m [16];
  logic [15:0] sw_exp;
  logic [31:0] q;
  xss_unit DUT (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_q(irq_q));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // **********
  // Helpers
  // **********
  function automatic logic [31:0] szm(input logic [1:0] s);
    return s == 2'h0 ? 32'hFF : s == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF;
  endfunction : szm
  // N from the top bit of the sized result, V and C cleared, X kept
  function automatic logic [15:0] nz(input logic [31:0] r, k);
    logic [15:0] f;
    f = sw_exp & 16'hFFF0;
    f[3] = |(r & k & ~(k >> 1));
    f[2] = (r & k) == 32'h0;
    return f;
  endfunction : nz
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40) fail_count++;
  endtask : bus
  task automatic setr(input int i, input logic [31:0] v);
    bus(1'b1, 6'(16 + i), v);
    m[i] = v;
  endtask : setr
  task automatic rd(input int i);
    bus(1'b0, 6'(16 + i), 32'h0);
    chk(q, m[i]);
  endtask : rd
  task automatic rdsw;
    bus(1'b0, 6'h02, 32'h0);
    chk(q, {16'h0, sw_exp});
  endtask : rdsw
  // Faults ignore the done bit and compare the illegal and privilege bits
  task automatic run(input logic [18:0] c, input logic [31:0] im,
    input logic [2:0] ev);
    int n;
    n = 0;
    bus(1'b1, 6'h01, im);
    bus(1'b1, 6'h00, {13'h0, c});
    do begin
      bus(1'b0, 6'h03, 32'h0);
      n++;
    end while (q[2:0] === 3'h0 && n < 20);
    chk({29'h0, q[2:0] & (ev[0] ? 3'h7 : 3'h6)}, {29'h0, ev});
    bus(1'b1, 6'h03, 32'h7);
  endtask : run
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  // **********
  // Tests
  // **********
  initial begin
    logic [31:0] v, im, r, k;
    logic [2:0] a, b, o;
    logic [1:0] z;
    logic [4:0] so;
    int i, ia, ib;
    nrst = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    fail_count = 0;
    tests_run = 0;
    sw_exp = xss_pkg::STATUS_RESET;
    foreach (m[n]) m[n] = 32'h0;
    v = $urandom(44);
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    rdsw();
    rd(3);
    bus(1'b1, 6'h05, 32'hFFFFFFFF);
    bus(1'b0, 6'h05, 32'h0);
    chk(q, 32'h0);
    // Lane enables: only bytes 0 and 2 are replaced
    setr(2, 32'h12345678);
    avs_byteenable <= 4'h5;
    bus(1'b1, 6'h12, 32'hA5A5A5A5);
    avs_byteenable <= 4'hF;
    m[2] = 32'h12A556A5;
    rd(2);
    endt("reset");
    for (i = 0; i < 4; i++) begin
      im = (i == 0) ? 32'h1F : {24'h0, 8'($urandom)};
      run({1'b1, 2'h3, 16'h0A3C}, im, 3'h1);
      sw_exp = sw_exp ^ (im[15:0] & xss_pkg::STATUS_IMPL_MASK);
      rdsw();
    end
    endt("ccb");
    for (i = 0; i < 9; i++) begin
      z = 2'(i % 3);
      a = 3'($urandom_range(7, 0));
      v = $urandom;
      im = (i < 3) ? v : $urandom;
      k = szm(z);
      setr(a, v);
      r = (v & ~k) | ((v ^ im) & k);
      run({3'h0, 8'h0A, z, 3'h0, a}, im, 3'h1);
      m[a] = r;
      sw_exp = nz(r, k);
      rd(a);
      rdsw();
    end
    endt("xor");
    for (i = 0; i < 9; i++) begin
      z = 2'(i % 3);
      o = (z == 0) ? xss_pkg::SX_BW :
          (z == 1) ? xss_pkg::SX_WL : xss_pkg::SX_BL;
      a = 3'($urandom_range(7, 0));
      v = (i < 3) ? 32'hA5A50080 : (i < 6) ? 32'hFFFF0000 : $urandom;
      r = (z == 0) ? {v[31:16], {8{v[7]}}, v[7:0]} :
          (z == 1) ? {{16{v[15]}}, v[15:0]} : {{24{v[7]}}, v[7:0]};
      setr(a, v);
      run({3'h2, 7'h24, o, 3'h0, a}, 32'h0, 3'h1);
      m[a] = r;
      sw_exp = nz(r, (z == 0) ? 32'hFFFF : 32'hFFFFFFFF);
      rd(a);
      rdsw();
    end
    endt("extend");
    for (i = 0; i < 6; i++) begin
      z = 2'(i % 3);
      so = (z == 0) ? xss_pkg::SWAP_DD :
           (z == 1) ? xss_pkg::SWAP_AA : xss_pkg::SWAP_DA;
      a = 3'($urandom_range(7, 0));
      b = 3'($urandom_range(7, 0));
      ia = ((z == 1) ? 8 : 0) + a;
      ib = ((z == 0) ? 0 : 8) + b;
      setr(ia, $urandom);
      setr(ib, $urandom);
      run({3'h1, 4'hC, a, 1'b1, so, b}, 32'h0, 3'h1);
      v = m[ia];
      m[ia] = m[ib];
      m[ib] = v;
      rd(ia);
      rd(ib);
      rdsw();
    end
    endt("swap");
    bus(1'b1, 6'h04, 32'h0);
    bus(1'b1, 6'h01, 32'h0);
    bus(1'b1, 6'h00, {13'h0, 1'b1, 2'h3, 16'h0A3C});
    repeat (10) @(posedge mclk);
    chk({31'h0, irq_q}, 32'h0);
    bus(1'b1, 6'h04, 32'h1);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq_q}, 32'h1);
    bus(1'b1, 6'h03, 32'h7);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq_q}, 32'h0);
    bus(1'b1, 6'h04, 32'h0);
    endt("irq");
    for (i = 0; i < 5; i++) begin
      im = (i == 4) ? 32'h2000 : ($urandom & 32'hDFFF);
      run({3'h3, 16'h0A7C}, im, 3'h1);
      sw_exp = sw_exp ^ (im[15:0] & xss_pkg::STATUS_IMPL_MASK);
      rdsw();
    end
    run({3'h3, 16'h0A7C}, $urandom, 3'h4);
    rdsw();
    bus(1'b1, 6'h02, 32'h0000FFFF);
    sw_exp = 16'hFFFF & xss_pkg::STATUS_IMPL_MASK;
    rdsw();
    endt("status");
    for (i = 8; i < 64; i++) begin
      o = 3'(i >> 3);
      run({3'h0, 8'h0A, 2'($urandom_range(2, 0)), 6'(i)}, $urandom,
        (o == 3'h1 || (o == 3'h7 && i[2:1] != 2'h0)) ? 3'h2 : 3'h1);
    end
    run({3'h0, 8'h0A, 2'h3, 6'h00}, 32'h0, 3'h2);
    rd(0);
    for (i = 8; i < 16; i++) rd(i);
    endt("modes");
    report_and_stop();
  end
endmodule : xss_unit_tb
